// file: rtl/dtg_guard.sv
`timescale 1ns/100ps
`default_nettype none
module dtg_guard (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [3:0] req_cmd,
    input wire logic req_bl8,
    input wire logic bc4_fixed,
    input wire logic ext_temp,
    input wire logic dll_relock,
    input wire logic [7:0] write_latency,
    input wire logic [7:0] read_latency,
    input wire logic [7:0] mode_register_zero_wr,
    input wire logic term_drop_req,
    output logic req_ready,
    output logic cmd_valid,
    output logic [3:0] cmd_out,
    output logic term_ctl,
    output logic refresh_due
);
    localparam int CW = dtg_pkg::CW;
    typedef struct packed {
        logic [CW-1:0] pd_wait;
        logic [CW-1:0] rfc_wait;
        logic [CW-1:0] refi_cnt;
        logic [CW-1:0] term_wait;
        logic [CW-1:0] lvl_en_wait;
        logic [CW-1:0] lvl_edge_wait;
        logic [CW-1:0] zq_wait;
        logic [CW-1:0] dll_wait;
        logic [CW-1:0] mod_wait;
        logic cmd_valid;
        logic [3:0] cmd_out;
        logic term_ctl;
        logic refresh_due;
    } dtg_state_t;
    dtg_state_t st, next_st;
    dtg_pkg::dtg_cmd_t cmd;
    logic [CW-1:0] wl, rl, wr_mr0, tail, pd_need;
    logic allowed;

    function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
        dec = (v == '0) ? v : v - dtg_pkg::ONE;
    endfunction
    function automatic logic [CW-1:0] mx(input logic [CW-1:0] a,
        input logic [CW-1:0] b);
        mx = (a > b) ? a : b;
    endfunction

    always_comb begin
        cmd = dtg_pkg::dtg_cmd_t'(req_cmd);
        wl = {8'h00, write_latency};
        rl = {8'h00, read_latency};
        wr_mr0 = {8'h00, mode_register_zero_wr};
        tail = bc4_fixed ? dtg_pkg::BURST_TAIL_SHORT
            : dtg_pkg::BURST_TAIL_LONG;
        pd_need = '0;
        unique case (cmd)
            dtg_pkg::DTG_WR: pd_need = wl + tail + dtg_pkg::WR_CYC;
            dtg_pkg::DTG_WRA: pd_need = wl + tail + wr_mr0
                + dtg_pkg::ONE;
            dtg_pkg::DTG_RD, dtg_pkg::DTG_RDA: pd_need = rl
                + dtg_pkg::BURST_TAIL_LONG + dtg_pkg::ONE;
            dtg_pkg::DTG_REF: pd_need = mx(dtg_pkg::REF_PD_CYC,
                dtg_pkg::XPDLL_CYC);
            dtg_pkg::DTG_MRS: pd_need = dtg_pkg::MOD_CYC;
            default: pd_need = '0;
        endcase
        allowed = (st.zq_wait == '0);
        unique case (cmd)
            dtg_pkg::DTG_ACT, dtg_pkg::DTG_REF:
                allowed = allowed && st.rfc_wait == '0;
            dtg_pkg::DTG_RD, dtg_pkg::DTG_RDA, dtg_pkg::DTG_ODT:
                allowed = allowed && st.dll_wait == '0;
            dtg_pkg::DTG_PDE:
                allowed = allowed && st.pd_wait == '0
                    && st.mod_wait == '0;
            dtg_pkg::DTG_STROBE_EN:
                allowed = st.lvl_en_wait == '0;
            dtg_pkg::DTG_STROBE_EDGE:
                allowed = st.lvl_edge_wait == '0;
            default: allowed = allowed;
        endcase
        req_ready = allowed;
        next_st = st;
        next_st.pd_wait = dec(st.pd_wait);
        next_st.rfc_wait = dec(st.rfc_wait);
        next_st.term_wait = dec(st.term_wait);
        next_st.lvl_en_wait = dec(st.lvl_en_wait);
        next_st.lvl_edge_wait = dec(st.lvl_edge_wait);
        next_st.zq_wait = dec(st.zq_wait);
        next_st.dll_wait = dec(st.dll_wait);
        next_st.mod_wait = dec(st.mod_wait);
        next_st.refi_cnt = dec(st.refi_cnt);
        next_st.cmd_valid = 1'b0;
        next_st.cmd_out = dtg_pkg::DTG_NOP;
        if (st.refi_cnt == dtg_pkg::ONE) begin
            next_st.refresh_due = 1'b1;
        end
        if (dll_relock) begin
            next_st.dll_wait = dtg_pkg::DLL_LOCK_CYC;
        end
        if (term_drop_req && st.term_wait == '0) begin
            next_st.term_ctl = 1'b0;
        end
        if (req_valid && allowed) begin
            next_st.cmd_valid = 1'b1;
            next_st.cmd_out = req_cmd;
            next_st.pd_wait = mx(next_st.pd_wait, pd_need);
            unique case (cmd)
                dtg_pkg::DTG_REF: begin
                    next_st.rfc_wait = dtg_pkg::RFC_CYC;
                    next_st.refresh_due = 1'b0;
                    next_st.refi_cnt = ext_temp ? dtg_pkg::REFI_EXT_CYC
                        : dtg_pkg::REFI_NORMAL_CYC;
                end
                dtg_pkg::DTG_MRS:
                    next_st.mod_wait = dtg_pkg::MOD_CYC;
                dtg_pkg::DTG_LVL: begin
                    next_st.lvl_en_wait =
                        dtg_pkg::LEVEL_STROBE_ENABLE_WAIT;
                    next_st.lvl_edge_wait =
                        dtg_pkg::LEVEL_FIRST_STROBE_WAIT;
                end
                dtg_pkg::DTG_ZQCS:
                    next_st.zq_wait = dtg_pkg::ZQ_SHORT_CYC;
                dtg_pkg::DTG_ODT: begin
                    next_st.term_ctl = 1'b1;
                    next_st.term_wait = mx(next_st.term_wait,
                        dtg_pkg::TERM_HIGH_MIN_SHORT - dtg_pkg::ONE);
                end
                dtg_pkg::DTG_WR, dtg_pkg::DTG_WRA:
                    if (st.term_ctl && req_bl8 && !bc4_fixed) begin
                        next_st.term_wait = mx(next_st.term_wait,
                            dtg_pkg::TERM_HIGH_MIN_LONG
                            - dtg_pkg::ONE);
                    end
                default: next_st.cmd_valid = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cmd_valid = st.cmd_valid;
    assign cmd_out = st.cmd_out;
    assign term_ctl = st.term_ctl;
    assign refresh_due = st.refresh_due;
endmodule
`default_nettype wire

// file: rtl/dtg_pkg.sv
// Notes on behaviour
// - write-autoprecharge to power-down: WL+4/2+WR+1 cycles
// - BC4 fixed write to pd: WL+2+recovery
// - recovery ns over period, rounded up
// - autoprecharge uses mode register zero WR
// - refresh to power-down at least 1 cycle
// - mode register set waits update delay
// - termination high 4 cycles, no/BC4 write
// - termination high 6 cycles with BL8 write
// - leveling first strobe edge after 40 cycles
// - leveling strobe enable after 25 cycles
// - refresh blocks activate, refresh 160 ns
// - average refresh interval 7.8 or 3.9 us
// - reads and sync termination need locked DLL
// - refresh to pd also honours frozen exit delay
// - short calibration needs 64 cycles
// - read to power-down waits RL+4+1 cycles
package dtg_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CW = 16;
    localparam int WRITE_RECOVERY_TIME_PS = 15000;
    localparam logic [CW-1:0] WR_CYC = CW'((WRITE_RECOVERY_TIME_PS
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int REFRESH_CYCLE_TIME_PS = 160000;
    localparam logic [CW-1:0] RFC_CYC = CW'((REFRESH_CYCLE_TIME_PS
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int REFI_NORMAL_NS = 7800;
    localparam int REFI_EXT_NS = 3900;
    localparam logic [CW-1:0] REFI_NORMAL_CYC = CW'(REFI_NORMAL_NS
        * 1000 / CLK_PERIOD_PS);
    localparam logic [CW-1:0] REFI_EXT_CYC = CW'(REFI_EXT_NS
        * 1000 / CLK_PERIOD_PS);
    localparam int MODE_UPDATE_DELAY_PS = 15000;
    localparam logic [CW-1:0] MOD_CYC = CW'((MODE_UPDATE_DELAY_PS
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) > 12 ? CW'((
        MODE_UPDATE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS)
        : 16'h000c;
    localparam int PD_EXIT_DLL_FROZEN_PS = 24000;
    localparam logic [CW-1:0] XPDLL_CYC = CW'((PD_EXIT_DLL_FROZEN_PS
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) > 10 ? CW'((
        PD_EXIT_DLL_FROZEN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS)
        : 16'h000a;
    localparam logic [CW-1:0] REF_PD_CYC = 16'h0001;
    localparam logic [CW-1:0] TERM_HIGH_MIN_SHORT = 16'h0004;
    localparam logic [CW-1:0] TERM_HIGH_MIN_LONG = 16'h0006;
    localparam logic [CW-1:0] LEVEL_FIRST_STROBE_WAIT = 16'h0028;
    localparam logic [CW-1:0] LEVEL_STROBE_ENABLE_WAIT = 16'h0019;
    localparam logic [CW-1:0] ZQ_SHORT_CYC = 16'h0040;
    localparam logic [CW-1:0] BURST_TAIL_LONG = 16'h0004;
    localparam logic [CW-1:0] BURST_TAIL_SHORT = 16'h0002;
    localparam logic [CW-1:0] ONE = 16'h0001;
    localparam logic [CW-1:0] DLL_LOCK_CYC = 16'h0200;
    typedef enum logic [3:0] {
        DTG_NOP, DTG_ACT, DTG_RD, DTG_RDA, DTG_WR, DTG_WRA, DTG_REF,
        DTG_MRS, DTG_ZQCS, DTG_ODT, DTG_PRE, DTG_LVL, DTG_PDE,
        DTG_STROBE_EN, DTG_STROBE_EDGE
    } dtg_cmd_t;
endpackage

// file: tb/dtg_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module dtg_mem_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_out,
    input wire logic bc4_fixed,
    input wire logic [7:0] write_latency,
    output logic wr_start,
    output logic in_pd
);
    logic [7:0] wcnt;
    assign wr_start = wcnt == 8'h01;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wcnt <= 8'h00;
            in_pd <= 1'b0;
        end else begin
            if (cmd_valid && cmd_out == dtg_pkg::DTG_WR) begin
                wcnt <= write_latency + (bc4_fixed ? 8'h02 : 8'h04);
            end else if (wcnt != 8'h00) begin
                wcnt <= wcnt - 8'h01;
            end
            if (cmd_valid) begin
                in_pd <= cmd_out == dtg_pkg::DTG_PDE;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/dtg_guard_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dtg_guard_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [3:0] req_cmd,
    input wire logic req_ready,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_out,
    input wire logic term_ctl
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire pde = cmd_valid && cmd_out == dtg_pkg::DTG_PDE;
    wire sen = cmd_valid && cmd_out == dtg_pkg::DTG_STROBE_EN;
    wire act = cmd_valid
        && cmd_out inside {dtg_pkg::DTG_ACT, dtg_pkg::DTG_REF};
    wire ref_v = cmd_valid && cmd_out == dtg_pkg::DTG_REF;
    wire mrs_v = cmd_valid && cmd_out == dtg_pkg::DTG_MRS;
    wire wr_v = cmd_valid && cmd_out == dtg_pkg::DTG_WR;
    wire zq_v = cmd_valid && cmd_out == dtg_pkg::DTG_ZQCS;
    wire lvl_v = cmd_valid && cmd_out == dtg_pkg::DTG_LVL;
    sequence no_pde8;
        !pde [*8];
    endsequence
    sequence no_sen8;
        !sen [*8];
    endsequence
    a_cmd_follows: assert property (
        req_valid && req_ready |=> cmd_valid && cmd_out == $past(req_cmd))
        else $error("lost command");
    a_ref_act_gap: assert property (ref_v |=> !act [*6])
        else $error("refresh gap short");
    a_ref_pd_gap: assert property (ref_v |=> no_pde8 ##1 !pde)
        else $error("refresh pd short");
    a_mrs_pd_gap: assert property (
        mrs_v |=> no_pde8 ##1 !pde [*3]) else $error("mode pd short");
    a_wr_pd_gap: assert property (wr_v |=> !pde [*7])
        else $error("write pd short");
    a_zq_quiet: assert property (zq_v |=> !act [*8])
        else $error("calibration gap short");
    a_lvl_en_wait: assert property (
        lvl_v |=> no_sen8 ##1 no_sen8 ##1 no_sen8)
        else $error("strobe early");
    a_term_min: assert property ($rose(term_ctl) |=> term_ctl [*3])
        else $error("termination short");
endmodule
bind dtg_guard dtg_guard_chk u_chk (.core_clk(core_clk), .rst(rst),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_ready(req_ready),
    .cmd_valid(cmd_valid), .cmd_out(cmd_out), .term_ctl(term_ctl));
`default_nettype wire

// file: tb/dtg_guard_test.sv
`timescale 1ns/100ps
`default_nettype none
module dtg_guard_test;
    logic core_clk = 0, rst = 1, req_valid = 0, req_bl8 = 0, bc4_fixed = 0;
    logic ext_temp = 0, dll_relock = 0, term_drop_req = 0;
    logic req_ready, cmd_valid, term_ctl, refresh_due;
    logic [3:0] req_cmd = 4'h0, cmd_out;
    logic [15:0] n;
    int err_count = 0, tests_run = 0;
    always #12.5 core_clk = ~core_clk;
    dtg_guard u_dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bl8(req_bl8), .bc4_fixed(bc4_fixed),
        .ext_temp(ext_temp), .dll_relock(dll_relock), .write_latency(8'h05),
        .read_latency(8'h06), .mode_register_zero_wr(8'h08),
        .term_drop_req(term_drop_req), .req_ready(req_ready), .cmd_out(cmd_out),
        .cmd_valid(cmd_valid), .term_ctl(term_ctl), .refresh_due(refresh_due));
    dtg_mem_model u_mem (.core_clk(core_clk), .rst(rst), .cmd_out(cmd_out),
        .cmd_valid(cmd_valid), .bc4_fixed(bc4_fixed), .write_latency(8'h05),
        .wr_start(), .in_pd());
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic issue(input logic [3:0] c);
        req_valid = 1;
        req_cmd = c;
        n = 0;
        forever begin
            #1;
            if (req_ready === 1'b1 || n > 600) break;
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
    endtask
    task automatic gap(input logic [3:0] a, input logic [3:0] b);
        issue(a);
        issue(b);
        req_valid = 0;
        repeat (80) @(negedge core_clk);
    endtask
    task automatic t_spacing();
        gap(dtg_pkg::DTG_REF, dtg_pkg::DTG_ACT);
        check(n, dtg_pkg::RFC_CYC);
        gap(dtg_pkg::DTG_REF, dtg_pkg::DTG_PDE);
        check(n, dtg_pkg::XPDLL_CYC);
        gap(dtg_pkg::DTG_MRS, dtg_pkg::DTG_PDE);
        check(n, dtg_pkg::MOD_CYC);
        gap(dtg_pkg::DTG_RDA, dtg_pkg::DTG_PDE);
        check(n, 16'h000b);
        gap(dtg_pkg::DTG_ZQCS, dtg_pkg::DTG_ACT);
        check(n, dtg_pkg::ZQ_SHORT_CYC);
        gap(dtg_pkg::DTG_LVL, dtg_pkg::DTG_STROBE_EN);
        check(n, 16'h0019);
        gap(dtg_pkg::DTG_LVL, dtg_pkg::DTG_STROBE_EDGE);
        check(n, 16'h0028);
    endtask
    task automatic t_write();
        for (int i = 0; i < 2; i++) begin
            bc4_fixed = i[0];
            gap(dtg_pkg::DTG_WR, dtg_pkg::DTG_PDE);
            check(n, 16'h0005 + (i ? 16'h0002 : 16'h0004) + 16'h0001);
            gap(dtg_pkg::DTG_WRA, dtg_pkg::DTG_PDE);
            check(n, 16'h0005 + (i ? 16'h0002 : 16'h0004) + 16'h0009);
        end
    endtask
    task automatic t_term();
        bc4_fixed = 0;
        term_drop_req = 1;
        issue(dtg_pkg::DTG_ODT);
        req_valid = 0;
        n = 0;
        repeat (12) begin
            n += 16'(term_ctl === 1'b1);
            @(negedge core_clk);
        end
        check(n, dtg_pkg::TERM_HIGH_MIN_SHORT);
        term_drop_req = 0;
        issue(dtg_pkg::DTG_ODT);
        req_bl8 = 1;
        issue(dtg_pkg::DTG_WR);
        req_valid = 0;
        term_drop_req = 1;
        n = 0;
        repeat (12) begin
            n += 16'(term_ctl === 1'b1);
            @(negedge core_clk);
        end
        check(n, dtg_pkg::TERM_HIGH_MIN_LONG);
        dll_relock = 1;
        @(negedge core_clk);
        dll_relock = 0;
        issue(dtg_pkg::DTG_RD);
        check(n, dtg_pkg::DLL_LOCK_CYC);
        ext_temp = 1;
        issue(dtg_pkg::DTG_REF);
        req_valid = 0;
        n = 0;
        while (refresh_due !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check(n, dtg_pkg::REFI_EXT_CYC);
    endtask
    task complete_run();
        $display("mismatches %0d, comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        err_count++;
        complete_run();
    end
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 0;
        t_spacing();
        t_write();
        t_term();
        complete_run();
    end
endmodule
`default_nettype wire
